// ===== core/rbac_regs.vh
// constants for the bit-sync and gain-limit configuration bank
// assumes a 32-bit axi4-lite bus, byte address = 4 * register index
`ifndef RBAC_REGS_VH
`define RBAC_REGS_VH

// register indices, byte address is four times these
`define RBAC_IDX_BIT_SYNC 18'h0df16
`define RBAC_IDX_GAIN_LIM 18'h0df17
`define RBAC_IDX_LOOP_CTL 18'h0df20

// reset values
`define RBAC_RST_BIT_SYNC 8'h6c
`define RBAC_RST_GAIN_LIM 8'h03
`define RBAC_RST_LOOP_CTL 1'b1

// bit-sync fields
`define RBAC_PRE_KI_HI 7
`define RBAC_PRE_KI_LO 6
`define RBAC_PRE_KP_HI 5
`define RBAC_PRE_KP_LO 4
`define RBAC_POST_KI 3
`define RBAC_POST_KP 2
`define RBAC_CLAMP_HI 1
`define RBAC_CLAMP_LO 0

// gain-limit fields
`define RBAC_DIG_HI 7
`define RBAC_DIG_LO 6
`define RBAC_FE_HI 5
`define RBAC_FE_LO 3
`define RBAC_AMP_HI 2
`define RBAC_AMP_LO 0

// loop control fields
`define RBAC_GATE_BIT 0
`define RBAC_PHASE_BIT 1
`define RBAC_FREEZE_BIT 2

// axi responses
`define RBAC_RESP_OKAY 2'b00
`define RBAC_RESP_SLVERR 2'b10

`endif

// ===== core/rbac_config.v
// bit-sync and gain-limit register bank with derived loop settings
// assumes sync_found, packet_end and carrier_sense come from aclk logic
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "rbac_regs.vh"

module rbac_config (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [19:0] awaddr,
    input wire [2:0] awprot,
    input wire awvalid,
    output reg awready,
    // axi4-lite write data
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    // axi4-lite write response
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // axi4-lite read address
    input wire [19:0] araddr,
    input wire [2:0] arprot,
    input wire arvalid,
    output reg arready,
    // axi4-lite read data
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // demodulator status
    input wire sync_found,
    input wire packet_end,
    input wire carrier_sense,
    // clock recovery settings
    output reg [3:0] integral_gain_halves,
    output reg [2:0] proportional_gain_mult,
    output reg [2:0] rate_clamp_32nds,
    output reg loop_freeze,
    // gain control settings
    output reg [1:0] digital_gain_ceiling,
    output reg [2:0] frontend_gain_ceiling,
    output reg [5:0] amplitude_goal_db
);

    // how the bank behaves on the bus and toward the loops:
    // - a write is stored one edge after the later of its address and data
    //   halves is taken; bvalid rises at that same edge
    // - nothing new is taken until the write response is handed over, so
    //   a second write cannot overtake the first
    // - a read answers at the same edge its address is taken
    // - only byte lane 0 carries register data; a write with wstrb[0] low
    //   is answered okay but stores nothing
    // - an unmapped index answers slverr and reads as zero
    // - the third word is local: gating enable, packet phase, freeze flag
    // - every loop output is registered once more, so a register write
    //   reaches the demodulator two edges after it is taken
    // - the phase flop adds one edge between sync detection and the
    //   post-sync gains; the loop tolerates that extra edge

    // software-visible storage
    reg [7:0] bit_sync_config_q;
    reg [7:0] gain_limit_target_q;
    reg loop_gate_on_carrier_q;
    // packet phase
    reg post_sync_q;
    // held write request
    reg [19:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    // derived settings before their output flops
    reg [3:0] ki_d;
    reg [2:0] kp_d;
    reg [2:0] clamp_d;
    reg [5:0] amp_d;
    reg [31:0] rd_d;
    reg rd_ok_d;
    wire wr_go;
    wire [17:0] wr_idx;
    wire [17:0] rd_idx;

    assign wr_idx = awaddr_q[19:2];
    assign rd_idx = araddr[19:2];
    // both halves of the write held and no response pending
    assign wr_go = ~awready & ~wready & ~bvalid;

    // write channels: each accepted on its own, in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RBAC_RESP_OKAY;
            awaddr_q <= 20'h00000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                if (wr_idx == `RBAC_IDX_BIT_SYNC ||
                    wr_idx == `RBAC_IDX_GAIN_LIM ||
                    wr_idx == `RBAC_IDX_LOOP_CTL) begin
                    bresp <= `RBAC_RESP_OKAY;
                end else begin
                    bresp <= `RBAC_RESP_SLVERR; // unmapped
                end
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // bit-sync register, only byte lane 0 carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            bit_sync_config_q <= `RBAC_RST_BIT_SYNC;
        end else if (wr_go && wstrb_q[0] &&
                     wr_idx == `RBAC_IDX_BIT_SYNC) begin
            bit_sync_config_q <= wdata_q[7:0];
        end
    end

    // gain-limit register, only byte lane 0 carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            gain_limit_target_q <= `RBAC_RST_GAIN_LIM;
        end else if (wr_go && wstrb_q[0] &&
                     wr_idx == `RBAC_IDX_GAIN_LIM) begin
            gain_limit_target_q <= wdata_q[7:0];
        end
    end

    // gating enable, the status bits of this word are read-only
    always @(posedge aclk) begin
        if (!aresetn) begin
            loop_gate_on_carrier_q <= `RBAC_RST_LOOP_CTL;
        end else if (wr_go && wstrb_q[0] &&
                     wr_idx == `RBAC_IDX_LOOP_CTL) begin
            loop_gate_on_carrier_q <= wdata_q[`RBAC_GATE_BIT];
        end
    end

    // read decode, upper bits read as zero
    always @* begin
        rd_d = 32'h00000000;
        rd_ok_d = 1'b1;
        case (rd_idx)
            `RBAC_IDX_BIT_SYNC: rd_d[7:0] = bit_sync_config_q;
            `RBAC_IDX_GAIN_LIM: rd_d[7:0] = gain_limit_target_q;
            `RBAC_IDX_LOOP_CTL: begin
                rd_d[`RBAC_GATE_BIT] = loop_gate_on_carrier_q;
                rd_d[`RBAC_PHASE_BIT] = post_sync_q;
                rd_d[`RBAC_FREEZE_BIT] = loop_freeze;
            end
            default: rd_ok_d = 1'b0;
        endcase
    end

    // read channel: one outstanding read, data one cycle after address
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RBAC_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_d;
                rresp <= rd_ok_d ? `RBAC_RESP_OKAY : `RBAC_RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // packet phase: sync wins over a same-cycle packet end
    always @(posedge aclk) begin
        if (!aresetn) begin
            post_sync_q <= 1'b0;
        end else if (sync_found) begin
            post_sync_q <= 1'b1;
        end else if (packet_end) begin
            post_sync_q <= 1'b0;
        end
    end

    // gain selection in half-steps so k/2 stays an integer
    always @* begin
        ki_d = {1'b0, bit_sync_config_q[`RBAC_PRE_KI_HI:`RBAC_PRE_KI_LO],
            1'b0} + 4'h2;
        kp_d = {1'b0, bit_sync_config_q[`RBAC_PRE_KP_HI:`RBAC_PRE_KP_LO]}
            + 3'h1;
        if (post_sync_q && bit_sync_config_q[`RBAC_POST_KI]) begin
            ki_d = 4'h1;
        end
        if (post_sync_q && bit_sync_config_q[`RBAC_POST_KP]) begin
            kp_d = 3'h1;
        end
    end

    // clamp in 1/32 units: 3.125 percent is one step
    always @* begin
        case (bit_sync_config_q[`RBAC_CLAMP_HI:`RBAC_CLAMP_LO])
            2'h0: clamp_d = 3'h0;
            2'h1: clamp_d = 3'h1;
            2'h2: clamp_d = 3'h2;
            default: clamp_d = 3'h4;
        endcase
    end

    // amplitude target table, steps are not uniform above 36 dB
    always @* begin
        case (gain_limit_target_q[`RBAC_AMP_HI:`RBAC_AMP_LO])
            3'h0: amp_d = 6'h18;
            3'h1: amp_d = 6'h1b;
            3'h2: amp_d = 6'h1e;
            3'h3: amp_d = 6'h21;
            3'h4: amp_d = 6'h24;
            3'h5: amp_d = 6'h26;
            3'h6: amp_d = 6'h28;
            default: amp_d = 6'h2a;
        endcase
    end

    // integral gain toward the clock recovery loop
    always @(posedge aclk) begin
        if (!aresetn) begin
            integral_gain_halves <= 4'h4;
        end else begin
            integral_gain_halves <= ki_d;
        end
    end

    // proportional gain toward the clock recovery loop
    always @(posedge aclk) begin
        if (!aresetn) begin
            proportional_gain_mult <= 3'h3;
        end else begin
            proportional_gain_mult <= kp_d;
        end
    end

    // rate offset clamp toward the loop
    always @(posedge aclk) begin
        if (!aresetn) begin
            rate_clamp_32nds <= 3'h0;
        end else begin
            rate_clamp_32nds <= clamp_d;
        end
    end

    // freeze follows the inverted carrier sense level, not latched, when gating is on
    always @(posedge aclk) begin
        if (!aresetn) begin
            loop_freeze <= 1'b0;
        end else begin
            loop_freeze <= loop_gate_on_carrier_q & ~carrier_sense;
        end
    end

    // digital gain ceiling toward gain control
    always @(posedge aclk) begin
        if (!aresetn) begin
            digital_gain_ceiling <= 2'h0;
        end else begin
            digital_gain_ceiling <=
                gain_limit_target_q[`RBAC_DIG_HI:`RBAC_DIG_LO];
        end
    end

    // front-end gain cap toward gain control
    always @(posedge aclk) begin
        if (!aresetn) begin
            frontend_gain_ceiling <= 3'h0;
        end else begin
            frontend_gain_ceiling <=
                gain_limit_target_q[`RBAC_FE_HI:`RBAC_FE_LO];
        end
    end

    // amplitude target in whole decibels
    always @(posedge aclk) begin
        if (!aresetn) begin
            amplitude_goal_db <= 6'h21;
        end else begin
            amplitude_goal_db <= amp_d;
        end
    end

endmodule // rbac_config

// ===== bench/rbac_config_properties.sv
// port-level checks for the bit-sync and gain-limit bank
// assumes the single aclk domain with synchronous active-low reset
`timescale 1ns/1ps
module rbac_config_chk (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // bus handshakes
    input logic awvalid,
    input logic awready,
    input logic wvalid,
    input logic wready,
    input logic [1:0] bresp,
    input logic bvalid,
    input logic bready,
    input logic arvalid,
    input logic arready,
    input logic [31:0] rdata,
    input logic rvalid,
    input logic rready,
    // demodulator side
    input logic carrier_sense,
    input logic [3:0] integral_gain_halves,
    input logic [2:0] proportional_gain_mult,
    input logic [2:0] rate_clamp_32nds,
    input logic loop_freeze,
    input logic [5:0] amplitude_goal_db
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready
        |-> ##2 bvalid) else $error("write not answered");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_RD_ANSWER: assert property (arvalid && arready
        |=> rvalid && rdata[31:8] == 24'h0) else $error("bad read answer");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_KI_SET: assert property (
        integral_gain_halves inside {1, 2, 4, 6, 8})
        else $error("integral gain off table");
    AST_KP_SET: assert property (
        proportional_gain_mult inside {[1:4]})
        else $error("proportional gain off table");
    AST_CLAMP_SET: assert property (
        rate_clamp_32nds inside {0, 1, 2, 4})
        else $error("clamp off table");
    AST_AMP_SET: assert property (
        amplitude_goal_db inside {24, 27, 30, 33, 36, 38, 40, 42})
        else $error("amp off");
    AST_FREEZE_CS: assert property (
        carrier_sense |=> !loop_freeze)
        else $error("loop frozen under carrier");
endmodule // rbac_config_chk
bind rbac_config rbac_config_chk u_chk (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
    .rvalid, .rready, .carrier_sense, .integral_gain_halves,
    .proportional_gain_mult, .rate_clamp_32nds, .loop_freeze,
    .amplitude_goal_db);

// ===== bench/rbac_config_tb_top.sv
// self-checking bench for the bit-sync and gain-limit bank
// assumes the bank answers on axi4-lite at 100 MHz, no partner model
`timescale 1ns/1ps
module rbac_config_tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, sync_found = 0, packet_end = 0;
    logic carrier_sense = 0, awready, wready, bvalid, arready, rvalid;
    logic loop_freeze;
    logic [19:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd_val;
    logic [3:0] wstrb = 0, integral_gain_halves;
    logic [1:0] bresp, rresp, rsp, digital_gain_ceiling;
    logic [2:0] proportional_gain_mult, rate_clamp_32nds, frontend_gain_ceiling;
    logic [5:0] amplitude_goal_db, amp_tbl [8] = '{24, 27, 30, 33, 36, 38, 40, 42};
    int bad_count = 0, checked = 0;
    rbac_config DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .sync_found, .packet_end, .carrier_sense, .integral_gain_halves,
        .proportional_gain_mult, .rate_clamp_32nds, .loop_freeze,
        .digital_gain_ceiling, .frontend_gain_ceiling, .amplitude_goal_db);
    // clock at 100 MHz
    initial begin
        forever #5 aclk = ~aclk;
    end
    task automatic stop_test();
        $display("bad_count %0d checked %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // bounded wait; a hang counts as a mismatch and ends the run
    task automatic guard(input int n);
        if (n > 100) begin
            bad_count++;
            $display("ERROR %0t: bus timeout", $time);
            stop_test();
        end
    endtask
    // address and data offered together, each dropped when taken
    task automatic wr(input logic [19:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        awaddr <= a; wdata <= {24'h0, d}; wstrb <= s;
        awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            n++;
            guard(n);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!(bready && bvalid));
        rsp = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [19:0] a);
        int n;
        n = 0;
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            n++;
            guard(n);
            if (arvalid && arready) arvalid <= 0;
        end while (!(rready && rvalid));
        rd_val = rdata;
        rsp = rresp;
        rready <= 0;
    endtask
    // one-cycle strobe on sync_found (0) or packet_end (1)
    task automatic pulse(input bit end_not_sync);
        if (end_not_sync)
            packet_end <= 1;
        else
            sync_found <= 1;
        tick(1);
        packet_end <= 0;
        sync_found <= 0;
        tick(3);
    endtask
    initial begin
        logic [7:0] v;
        tick(8);
        aresetn <= 1;
        tick(2);
        chk(loop_freeze, 1);
        rd(20'h37c58); chk(rd_val, 32'h6c);
        chk({integral_gain_halves, proportional_gain_mult}, 7'h23);
        rd(20'h37c5c); chk(rd_val, 32'h03);
        chk(amplitude_goal_db, 6'h21);
        for (int i = 0; i < 8; i++) begin
            v = {i[1:0], i[2:0], i[2:0]};
            wr(20'h37c5c, v, 4'h1); tick(2);
            chk({digital_gain_ceiling, frontend_gain_ceiling}, v[7:3]);
            chk(amplitude_goal_db, amp_tbl[i]);
        end
        for (int i = 0; i < 8; i++) begin
            v = {i[2:1], 2'(3 - i / 2), i[0], i[0], i[2:1]};
            wr(20'h37c58, v, 4'h1); tick(2);
            rd(20'h37c58); chk(rd_val, {24'h0, v});
            chk(integral_gain_halves, 2 * (i / 2 + 1));
            chk(proportional_gain_mult, 4 - i / 2);
            chk(rate_clamp_32nds, i / 2 == 3 ? 4 : i / 2);
            pulse(1'b0);
            chk(integral_gain_halves, i[0] ? 1 : 2 * (i / 2 + 1));
            chk(proportional_gain_mult, i[0] ? 1 : 4 - i / 2);
            pulse(1'b1);
            chk(integral_gain_halves, 2 * (i / 2 + 1));
        end
        // refused stores leave the register as it was
        wr(20'h37c5c, 8'h55, 4'h0); chk(rsp, 2'b00);
        rd(20'h37c5c); chk(rd_val, 32'hff);
        wr(20'h00010, 8'hff, 4'h1); chk(rsp, 2'b10);
        rd(20'h00010); chk(rsp, 2'b10);
        chk(rd_val, 32'h0);
        carrier_sense <= 1; tick(2); chk(loop_freeze, 0);
        carrier_sense <= 0; tick(2); chk(loop_freeze, 1);
        wr(20'h37c80, 8'h00, 4'h1); tick(2); chk(loop_freeze, 0);
        stop_test();
    end
endmodule // rbac_config_tb_top
